// >>> ipc_top.sv
/*
  Two-level interrupt priority controller with APB registers.
  Assumes the core pulses insn_done at each instruction end, accepts a
  vectored call on call_req, and pulses ret_done when a return completes.
*/
// The APB interface to the registers and the register offsets were left to the implementer.
// Operation
// RL1 - Twenty-three sources, each at one of two levels.
// RL2 - Pending flag sets on its event regardless of any enable.
// RL3 - Enabled pending source requests a vectored call after current instruction.
// RL4 - Return resumes interrupted code and ends the active level.
// RL5 - Disabled source's pending flag raises no request.
// RL6 - Each source has its own enable bit in three enable registers.
// RL7 - Gate bit 7 of primary enable register blocks all sources.
// RL8 - Enable cleared mid-instruction: one-cycle follow-on may still take request.
// RL9 - Cleared enable bit reads zero inside the entered routine.
// RL10 - Some flags clear on vectoring; software clears the rest.
// RL11 - Flag still set after return re-enters after one more instruction.
// RL12 - Software writing one to a flag acts like the event; here a same-cycle hardware clear of that flag overrides the written one.
// RL13 - Each source has a level bit, low after reset.
// RL14 - High preempts low; high routines are never preempted.
// RL15 - Higher level first, then fixed source order.
// RL16 - Sampled each cycle; best response one detect plus four call cycles.
// RL17 - Worst response eighteen cycles: return then divide before call.
// RL18 - Equal or lower level waits for return plus one instruction.
// RL19 - Reset clears enables, gate, levels and service state.
// RL20 - Low and high service tracked apart; return ends highest.
`timescale 1ns/10ps
module ipc_top (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ipc_pkg::IPC_NSRC-1:0] src_event,
  input wire logic insn_done,
  input wire logic ret_done,
  output logic call_req,
  output logic [4:0] call_index,
  output logic [15:0] call_vector,
  output logic in_service_low,
  output logic in_service_high
);
  import ipc_pkg::*;

  logic [7:0] en_pri_reg, en_ext1_reg, en_ext2_reg;
  logic [7:0] lvl_pri_reg, lvl_ext1_reg, lvl_ext2_reg;
  logic [22:0] pend_reg, pend_next;
  logic act_low_reg, act_high_reg;
  logic hold_reg;
  logic [1:0] call_cnt_reg;
  logic [4:0] idx_reg;
  logic [31:0] rdata_reg;
  ipc_state_t state_reg;
  logic [22:0] event_s1_reg, event_s2_reg;

  wire wr_stb, rd_stb;
  wire [7:0] reg_addr;
  wire addr_ok = (reg_addr[1:0] == 2'b00) && (reg_addr <= IPC_OFF_STATUS);

  ipc_apb_slave u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .reg_addr(reg_addr),
    .addr_ok(addr_ok)
  );

  // Enable and level vectors, primary 7 bits plus two 8-bit extensions
  wire [22:0] en_vec = {en_ext2_reg, en_ext1_reg, en_pri_reg[6:0]}; // [RL6]
  wire [22:0] lvl_vec = {lvl_ext2_reg, lvl_ext1_reg, lvl_pri_reg[6:0]}; // [RL1]
  wire gate = en_pri_reg[IPC_GATE_BIT];
  wire [22:0] live = pend_reg & en_vec & {23{gate}}; // [RL5] [RL7]
  wire [22:0] hi_req = live & lvl_vec;
  wire [22:0] lo_req = live & ~lvl_vec;

  wire hi_found, lo_found;
  wire [4:0] hi_idx, lo_idx;
  ipc_arbiter u_arb_hi (.req(hi_req), .found(hi_found), .index(hi_idx));
  ipc_arbiter u_arb_lo (.req(lo_req), .found(lo_found), .index(lo_idx));

  // Level choice: high first, low only when nothing in service [RL15]
  wire hi_ok = hi_found & ~act_high_reg; // [RL14]
  wire lo_ok = lo_found & ~act_high_reg & ~act_low_reg; // [RL18]
  wire take = (state_reg == IPC_IDLE) & insn_done & ~hold_reg
              & (hi_ok | lo_ok); // [RL3] [RL8] [RL16]
  wire [4:0] win_idx = hi_ok ? hi_idx : lo_idx;
  wire win_high = hi_ok;

  // Vector = 8*index + 3
  wire [15:0] vec_of_idx = {8'h00, win_idx, 3'b011};

  // Event inputs from peripherals pass through a two-stage synchroniser
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      event_s1_reg <= IPC_PEND_RESET;
      event_s2_reg <= IPC_PEND_RESET;
    end else begin
      event_s1_reg <= src_event;
      event_s2_reg <= event_s1_reg;
    end
  end

  wire pend_wr = wr_stb & (reg_addr == IPC_OFF_PEND);
  wire [22:0] hw_clr = (take ? (23'h000001 << win_idx) : 23'h000000)
                       & IPC_HW_CLEAR_MASK; // [RL10]

  // An event wins over clear; a written one sets the flag but loses to a same-cycle hardware clear
  always_comb begin
    pend_next = pend_reg;
    if (pend_wr) begin
      pend_next = pwdata[22:0]; // [RL12]
    end
    pend_next = (pend_next & ~hw_clr) | event_s2_reg; // [RL2]
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_reg <= IPC_PEND_RESET;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // Enable and level registers, all zero at reset [RL13] [RL19]
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_pri_reg <= IPC_EN_RESET;
      en_ext1_reg <= IPC_EN_RESET;
      en_ext2_reg <= IPC_EN_RESET;
      lvl_pri_reg <= IPC_LVL_RESET;
      lvl_ext1_reg <= IPC_LVL_RESET;
      lvl_ext2_reg <= IPC_LVL_RESET;
    end else if (wr_stb) begin
      unique case (reg_addr)
        IPC_OFF_EN_PRI: en_pri_reg <= pwdata[7:0];
        IPC_OFF_EN_EXT1: en_ext1_reg <= pwdata[7:0];
        IPC_OFF_EN_EXT2: en_ext2_reg <= pwdata[7:0];
        IPC_OFF_LVL_PRI: lvl_pri_reg <= {1'b0, pwdata[6:0]};
        IPC_OFF_LVL_EXT1: lvl_ext1_reg <= pwdata[7:0];
        IPC_OFF_LVL_EXT2: lvl_ext2_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // One-instruction hold after an enable write or a return [RL8] [RL11]
  wire en_wr = wr_stb & (reg_addr <= IPC_OFF_EN_EXT2);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_reg <= 1'b0;
    end else if (ret_done | en_wr) begin
      hold_reg <= 1'b1;
    end else if (insn_done) begin
      hold_reg <= 1'b0;
    end
  end

  // Call sequence and service levels [RL20]
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= IPC_IDLE;
      call_cnt_reg <= 2'd0;
      idx_reg <= IPC_NO_SRC;
      act_low_reg <= 1'b0;
      act_high_reg <= 1'b0;
      call_vector <= 16'h0000;
    end else begin
      unique case (state_reg)
        IPC_IDLE: begin
          if (take) begin
            state_reg <= IPC_CALL;
            call_cnt_reg <= 2'(IPC_CALL_CYCLES - 1);
            idx_reg <= win_idx;
            call_vector <= vec_of_idx;
            if (win_high) begin
              act_high_reg <= 1'b1;
            end else begin
              act_low_reg <= 1'b1;
            end
          end else if (ret_done) begin
            if (act_high_reg) begin
              act_high_reg <= 1'b0; // [RL4]
            end else begin
              act_low_reg <= 1'b0;
            end
          end
        end
        IPC_CALL: begin
          call_cnt_reg <= call_cnt_reg - 2'd1;
          if (call_cnt_reg == 2'd0) begin
            state_reg <= IPC_IDLE; // [RL16] [RL17]
          end
        end
      endcase
    end
  end

  assign call_req = (state_reg == IPC_CALL);
  assign call_index = idx_reg;
  assign in_service_low = act_low_reg;
  assign in_service_high = act_high_reg;

  // Readback reflects live register state, so cleared bits read zero [RL9]
  wire [31:0] status_word = {29'h0, act_high_reg, act_low_reg, call_req};
  wire [31:0] rd_mux =
    (reg_addr == IPC_OFF_EN_PRI) ? {24'h0, en_pri_reg} :
    (reg_addr == IPC_OFF_EN_EXT1) ? {24'h0, en_ext1_reg} :
    (reg_addr == IPC_OFF_EN_EXT2) ? {24'h0, en_ext2_reg} :
    (reg_addr == IPC_OFF_LVL_PRI) ? {24'h0, lvl_pri_reg} :
    (reg_addr == IPC_OFF_LVL_EXT1) ? {24'h0, lvl_ext1_reg} :
    (reg_addr == IPC_OFF_LVL_EXT2) ? {24'h0, lvl_ext2_reg} :
    (reg_addr == IPC_OFF_PEND) ? {9'h0, pend_reg} :
    (reg_addr == IPC_OFF_STATUS) ? status_word : 32'h00000000;

  // Read data registered in the setup cycle, so access stays zero-wait
  wire rd_setup = psel & ~penable & ~pwrite;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 32'h00000000;
    end else if (rd_setup) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  assign prdata = rdata_reg;

  // Assertions
  sequence call_start_s;
    !call_req ##1 call_req;
  endsequence

  call_length_a: assert property ( // [RL16]
    @(posedge ref_clk) disable iff (!reset_n)
    call_start_s |-> call_req [*4] ##1 !call_req)
    else $error("call phase not four cycles");

  no_gate_a: assert property ( // [RL7]
    @(posedge ref_clk) disable iff (!reset_n)
    (!gate && state_reg == IPC_IDLE) |=> !call_req)
    else $error("call raised with gate low");

  disabled_src_a: assert property ( // [RL5]
    @(posedge ref_clk) disable iff (!reset_n)
    (take) |-> en_vec[win_idx])
    else $error("disabled source taken");

  high_no_preempt_a: assert property ( // [RL14]
    @(posedge ref_clk) disable iff (!reset_n)
    act_high_reg && !ret_done |=> !$rose(call_req))
    else $error("high routine preempted");

  event_sets_a: assert property ( // [RL2]
    @(posedge ref_clk) disable iff (!reset_n)
    (|event_s2_reg) |=> ((pend_reg & $past(event_s2_reg)) ==
                         $past(event_s2_reg)))
    else $error("event lost");

  level_order_a: assert property ( // [RL15]
    @(posedge ref_clk) disable iff (!reset_n)
    take && hi_ok |=> act_high_reg && call_index == $past(hi_idx))
    else $error("high level not first");

  hold_after_ret_a: assert property ( // [RL11]
    @(posedge ref_clk) disable iff (!reset_n)
    ret_done |=> !take)
    else $error("call without one instruction after return");

  ret_ends_high_a: assert property ( // [RL20]
    @(posedge ref_clk) disable iff (!reset_n)
    ret_done && !take && act_high_reg && act_low_reg
    |=> !act_high_reg && act_low_reg)
    else $error("return ended wrong level");
endmodule

// >>> ipc_pkg.sv
/*
  Constants for the two-level interrupt priority controller: source count,
  register offsets and layout, reset values and core handshake timing.
  Assumes one 40 MHz clock and an APB register port.
*/
package ipc_pkg;
  localparam int IPC_NSRC = 23;
  localparam int IPC_GATE_BIT = 7;
  localparam logic [7:0] IPC_OFF_EN_PRI = 8'h00;
  localparam logic [7:0] IPC_OFF_EN_EXT1 = 8'h04;
  localparam logic [7:0] IPC_OFF_EN_EXT2 = 8'h08;
  localparam logic [7:0] IPC_OFF_LVL_PRI = 8'h0C;
  localparam logic [7:0] IPC_OFF_LVL_EXT1 = 8'h10;
  localparam logic [7:0] IPC_OFF_LVL_EXT2 = 8'h14;
  localparam logic [7:0] IPC_OFF_PEND = 8'h18;
  localparam logic [7:0] IPC_OFF_STATUS = 8'h1C;
  localparam logic [7:0] IPC_EN_RESET = 8'h00;
  localparam logic [7:0] IPC_LVL_RESET = 8'h00;
  localparam logic [22:0] IPC_PEND_RESET = 23'h000000;
  localparam logic [22:0] IPC_HW_CLEAR_MASK = 23'h01800F;
  localparam int IPC_CLK_MHZ = 40;
  localparam int IPC_CALL_CYCLES = 4;
  localparam int IPC_DETECT_CYCLES = 1;
  localparam logic [4:0] IPC_NO_SRC = 5'h1F;
  typedef enum logic [1:0] {IPC_IDLE, IPC_CALL} ipc_state_t;
endpackage

// >>> ipc_apb_slave.sv
/*
  APB slave front end: zero-wait access, write and read strobes.
  Assumes the master holds the request until pready is seen.
*/
`timescale 1ns/10ps
module ipc_apb_slave (
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  output logic pready,
  output logic pslverr,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] reg_addr,
  input wire logic addr_ok
);
  wire access = psel & penable;
  assign pready = 1'b1;
  assign pslverr = access & ~addr_ok;
  assign wr_stb = access & pwrite & addr_ok;
  assign rd_stb = access & ~pwrite;
  assign reg_addr = paddr;
endmodule

// >>> ipc_arbiter.sv
/*
  Fixed-order arbiter: lowest index among requests wins.
  Assumes requests already gated by enable and level.
*/
`timescale 1ns/10ps
module ipc_arbiter (
  input wire logic [22:0] req,
  output logic found,
  output logic [4:0] index
);
  import ipc_pkg::*;
  always_comb begin
    found = 1'b0;
    index = IPC_NO_SRC;
    for (int i = IPC_NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        index = 5'(i);
      end
    end
  end
endmodule

// >>> ipc_core_model.sv
/*
  Core model: retires two-cycle instructions, stalls while a call runs,
  and issues a return on command. Assumes the ipc_top core handshake.
*/
`timescale 1ns/10ps
module ipc_core_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic call_req,
  input wire logic ret_cmd,
  output logic insn_done,
  output logic ret_done
);
  logic cnt_reg;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 1'b0;
      insn_done <= 1'b0;
      ret_done <= 1'b0;
    end else begin
      // No instruction ends while the call runs
      insn_done <= !call_req && !ret_cmd && cnt_reg;
      ret_done <= ret_cmd && !call_req;
      cnt_reg <= (call_req || ret_cmd) ? 1'b0 : !cnt_reg;
    end
  end
endmodule

// >>> ipc_top_bench.sv
/*
  Self-checking bench for ipc_top: APB master tasks, source events and
  a core model. Assumes the zero-wait APB slave and 4-cycle call.
*/
`timescale 1ns/10ps
module ipc_top_bench;
  import ipc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic last_err;
  logic [22:0] src_event = 23'h000000;
  logic insn_done;
  logic ret_done;
  logic ret_cmd = 1'b0;
  logic call_req;
  logic [4:0] call_index;
  logic [15:0] call_vector;
  logic in_service_low;
  logic in_service_high;
  int failures = 0;
  int total_checks = 0;
  logic [31:0] q;
  always #12.5 ref_clk = ~ref_clk;
  ipc_top ipc_top_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_event(src_event), .insn_done(insn_done),
    .ret_done(ret_done), .call_req(call_req), .call_index(call_index),
    .call_vector(call_vector), .in_service_low(in_service_low),
    .in_service_high(in_service_high));
  ipc_core_model ipc_core_model_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .call_req(call_req), .ret_cmd(ret_cmd),
    .insn_done(insn_done), .ret_done(ret_done));
  task automatic check(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] a,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    check(n, q, e);
  endtask
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      if (call_req !== 1'b0) seen = 1'b1;
    end
    check("no call", seen, 1'b0);
  endtask
  task automatic wait_call(input logic [4:0] idx);
    int n;
    n = 0;
    do @(posedge ref_clk); while (call_req !== 1'b1);
    check("call index", call_index, idx);
    check("call vector", call_vector, 16'(idx) * 16'h0008 + 16'h0003);
    while (call_req === 1'b1 && n < 10) begin
      n++;
      @(posedge ref_clk);
    end
    check("call length", n, IPC_CALL_CYCLES);
  endtask
  task automatic do_ret;
    @(posedge ref_clk);
    ret_cmd <= 1'b1;
    @(posedge ref_clk);
    ret_cmd <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic t_reset;
    for (int a = 0; a < 32; a += 4)
      rd("reset value", 8'(a), 32'h00000000);
    rd("unmapped data", 8'h20, 32'h00000000);
    check("unmapped err", last_err, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_basic;
    @(posedge ref_clk);
    src_event[4] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    src_event[4] <= 1'b0;
    quiet(20);
    rd("pending set", IPC_OFF_PEND, 32'h00000010);
    apb(1'b1, IPC_OFF_EN_PRI, 32'h00000010);
    quiet(20);
    apb(1'b1, IPC_OFF_EN_PRI, 32'h00000090);
    wait_call(5'h04);
    check("low active", in_service_low, 1'b1);
    do_ret();
    wait_call(5'h04);
    apb(1'b1, IPC_OFF_PEND, 32'h00000000);
    do_ret();
    quiet(20);
    check("low ended", in_service_low, 1'b0);
    $display("test basic done");
  endtask
  task automatic t_prio;
    apb(1'b1, IPC_OFF_EN_PRI, 32'h00000082);
    apb(1'b1, IPC_OFF_EN_EXT1, 32'h00000004);
    apb(1'b1, IPC_OFF_LVL_EXT1, 32'h00000004);
    apb(1'b1, IPC_OFF_PEND, 32'h00000202);
    wait_call(5'h09);
    check("high active", in_service_high, 1'b1);
    quiet(20);
    apb(1'b1, IPC_OFF_PEND, 32'h00000002);
    do_ret();
    wait_call(5'h01);
    rd("hw clear", IPC_OFF_PEND, 32'h00000000);
    apb(1'b1, IPC_OFF_PEND, 32'h00000200);
    wait_call(5'h09);
    apb(1'b1, IPC_OFF_PEND, 32'h00000000);
    do_ret();
    check("high ended", in_service_high, 1'b0);
    check("low kept", in_service_low, 1'b1);
    do_ret();
    check("low ended", in_service_low, 1'b0);
    $display("test priority done");
  endtask
  task automatic t_regs;
    apb(1'b1, IPC_OFF_EN_EXT2, 32'h000000A5);
    rd("ext2 enable", IPC_OFF_EN_EXT2, 32'h000000A5);
    apb(1'b1, IPC_OFF_LVL_PRI, 32'h000000FF);
    rd("primary level", IPC_OFF_LVL_PRI, 32'h0000007F);
    apb(1'b1, IPC_OFF_LVL_EXT2, 32'h0000005A);
    rd("ext2 level", IPC_OFF_LVL_EXT2, 32'h0000005A);
    apb(1'b1, IPC_OFF_STATUS, 32'h00000007);
    rd("status", IPC_OFF_STATUS, 32'h00000000);
    // Reset in mid-run must clear every register again
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    $display("test registers done");
    t_reset();
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_basic();
    t_prio();
    t_regs();
    summarize();
  end
endmodule
